//--- src/pxb_params.svh
// Purpose: constants shared by both bus ends
// Assumes: single bus clock CLK_I
// Notes:   offsets, window mask, encodings, counts and reset word only
`ifndef PXB_PARAMS_SVH
`define PXB_PARAMS_SVH
`define PXB_CMD_MEM_RD  4'h6
`define PXB_CMD_MEM_WR  4'h7
`define PXB_CBE_UPPER   4'h0
`define PXB_DEV_BASE    64'h0000_0000_8000_0000
`define PXB_HOST_BASE   64'h0000_0000_0000_0000
`define PXB_WIN_MASK    64'hffff_ffff_ffff_f000
`define PXB_DEVSEL_WAIT 3'h4
`define PXB_RESET_WORD  64'h0000_0000_0000_0000
`define PXB_FIFO_WIDTH  72
`define PXB_FIFO_DEPTH  16
`endif

//--- src/pxb_pkg.sv
// Purpose: state types of the bus ends
// Assumes: nothing
// Notes:   shared by both ends
package pxb_pkg;
	typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} pxb_mst_t;
	typedef enum logic [1:0] {T_IDLE, T_DATA, T_TURN} pxb_tgt_t;
endpackage

//--- src/pxb_bus_if.sv
// Purpose: shared parallel bus between device end and host end
// Assumes: released lines float high through pull-ups
// Notes:   each end drives value plus enable; wire level resolved here
interface pxb_bus_if;
	logic [63:0] d_ad, h_ad, ad;
	logic [7:0]  d_cbe_n, h_cbe_n, cbe_n;
	logic        d_ad_oe, h_ad_oe, d_cbe_oe, h_cbe_oe;
	logic        d_frame_n, h_frame_n, d_irdy_n, h_irdy_n, d_mctl_oe, h_mctl_oe;
	logic        d_trdy_n, h_trdy_n, d_devsel_n, h_devsel_n;
	logic        d_ack64_n, h_ack64_n, d_tctl_oe, h_tctl_oe;
	logic        d_par, h_par, d_par_oe, h_par_oe;
	logic        frame_n, irdy_n, trdy_n, devsel_n, ack64_n, par;
	logic        req_n, gnt_n;

	// ==========================================================
	// wire resolution
	assign ad       = d_ad_oe ? d_ad : (h_ad_oe ? h_ad : '1);
	assign cbe_n    = d_cbe_oe ? d_cbe_n : (h_cbe_oe ? h_cbe_n : '1);
	assign frame_n  = d_mctl_oe ? d_frame_n : (h_mctl_oe ? h_frame_n : 1'b1);
	assign irdy_n   = d_mctl_oe ? d_irdy_n : (h_mctl_oe ? h_irdy_n : 1'b1);
	assign trdy_n   = d_tctl_oe ? d_trdy_n : (h_tctl_oe ? h_trdy_n : 1'b1);
	assign devsel_n = d_tctl_oe ? d_devsel_n : (h_tctl_oe ? h_devsel_n : 1'b1);
	assign ack64_n  = d_tctl_oe ? d_ack64_n : (h_tctl_oe ? h_ack64_n : 1'b1);
	assign par      = d_par_oe ? d_par : (h_par_oe ? h_par : 1'b1);

	modport dev (
		output d_ad, d_ad_oe, d_cbe_n, d_cbe_oe, d_frame_n, d_irdy_n, d_mctl_oe,
		output d_trdy_n, d_devsel_n, d_ack64_n, d_tctl_oe, d_par, d_par_oe, req_n,
		input  ad, cbe_n, frame_n, irdy_n, trdy_n, devsel_n, ack64_n, par, gnt_n
	);
	modport host (
		output h_ad, h_ad_oe, h_cbe_n, h_cbe_oe, h_frame_n, h_irdy_n, h_mctl_oe,
		output h_trdy_n, h_devsel_n, h_ack64_n, h_tctl_oe, h_par, h_par_oe, gnt_n,
		input  ad, cbe_n, frame_n, irdy_n, trdy_n, devsel_n, ack64_n, par, req_n
	);
endinterface

//--- src/pxb_fifo.sv
// Purpose: synchronous valid/ready FIFO
// Assumes: one clock, synchronous active-high reset
// Notes:   no write when full, no read when empty
module pxb_fifo #(
	parameter int WIDTH = 72,
	parameter int DEPTH = 16
) (
	// system
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic             push, pop;

	assign in_ready_o  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
	assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
	assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb begin
		wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
		rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
		end
		if (push) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
		end
	end
endmodule

//--- src/pxb_dev_end.sv
// Purpose: device end of the bus, master and target in one agent
// Assumes: host end arbitrates; one data phase per own master transfer
// Notes:   target writes queue into a FIFO; a full FIFO holds off target ready
`include "pxb_params.svh"

// Operation
// - master frames transaction, releases in last phase
// - target asserts device select on address hit
// - master watches device select for a claim
// - claiming target asserts 64-bit acknowledge
// - address phase then data phases, shared lanes
// - lane 63:56 most, 7:0 least significant
// - command in address phase, enables in data
// - byte enables steady for whole data phase
// - everything timed by the one bus clock
// - phase completes when both ready lines low
// - even parity low lanes, one clock later
// - master starts only after arbiter grant
module pxb_dev_end import pxb_pkg::*; (
	// system
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// bus
	pxb_bus_if.dev           BUS,
	// master request
	input  wire logic        MST_START_I,
	input  wire logic        MST_WRITE_I,
	input  wire logic [63:0] MST_ADDR_I,
	input  wire logic [63:0] MST_DATA_I,
	input  wire logic [7:0]  MST_BE_N_I,
	// master answer
	output logic             MST_BUSY_O,
	output logic             MST_DONE_O,
	output logic             MST_ABORT_O,
	output logic      [63:0] MST_RDATA_O,
	// target read data
	input  wire logic [63:0] TGT_RDATA_I,
	output logic             TGT_RD_O,
	// target write stream
	output logic             RX_VALID_O,
	input  wire logic        RX_READY_I,
	output logic      [71:0] RX_DATA_O
);
	pxb_mst_t    m_state_reg, m_state_next;
	pxb_tgt_t    t_state_reg, t_state_next;
	logic [63:0] m_addr_reg, m_addr_next, m_data_reg, m_data_next;
	logic [63:0] m_rdata_reg, m_rdata_next, t_rdata_reg, t_rdata_next;
	logic [7:0]  m_be_n_reg, m_be_n_next;
	logic        m_wr_reg, m_wr_next, t_wr_reg, t_wr_next;
	logic [2:0]  m_cnt_reg, m_cnt_next;
	logic        done_reg, done_next, abort_reg, abort_next;
	logic        frame_prev_reg, par_reg, par_next, par_oe_reg, par_oe_next;
	logic        frame_start, hit, cmd_ok, m_ad_oe, t_ad_oe, t_trdy_n;
	logic        t_xfer, fifo_in_ready;

	// ==========================================================
	// master sequencing
	always_comb begin
		m_state_next = m_state_reg;
		m_addr_next  = m_addr_reg;
		m_data_next  = m_data_reg;
		m_be_n_next  = m_be_n_reg;
		m_wr_next    = m_wr_reg;
		m_rdata_next = m_rdata_reg;
		m_cnt_next   = m_cnt_reg;
		done_next    = 1'b0;
		abort_next   = 1'b0;
		unique case (m_state_reg)
			M_IDLE: begin
				if (MST_START_I) begin
					m_addr_next  = MST_ADDR_I;
					m_data_next  = MST_DATA_I;
					m_be_n_next  = MST_BE_N_I;
					m_wr_next    = MST_WRITE_I;
					m_state_next = M_REQ;
				end
			end
			M_REQ: begin
				if (!BUS.gnt_n && BUS.frame_n && BUS.irdy_n) begin
					m_state_next = M_ADDR;
				end
			end
			M_ADDR: begin
				m_cnt_next   = '0;
				m_state_next = M_DATA;
			end
			M_DATA: begin
				if (!BUS.trdy_n) begin
					if (!m_wr_reg) begin
						m_rdata_next = BUS.ad;
					end
					done_next    = 1'b1;
					m_state_next = M_TURN;
				end else if (BUS.devsel_n && m_cnt_reg == `PXB_DEVSEL_WAIT) begin
					abort_next   = 1'b1;
					m_state_next = M_TURN;
				end else if (m_cnt_reg != `PXB_DEVSEL_WAIT) begin
					m_cnt_next = m_cnt_reg + 3'h1;
				end
			end
			M_TURN: begin
				m_state_next = M_IDLE;
			end
		endcase
	end

	// ==========================================================
	// target sequencing
	assign frame_start = !BUS.frame_n && frame_prev_reg;
	assign hit         = (BUS.ad & `PXB_WIN_MASK) == `PXB_DEV_BASE;
	assign cmd_ok      = BUS.cbe_n[3:0] == `PXB_CMD_MEM_RD || BUS.cbe_n[3:0] == `PXB_CMD_MEM_WR;
	assign t_trdy_n    = !(t_state_reg == T_DATA && (!t_wr_reg || fifo_in_ready));
	assign t_xfer      = t_state_reg == T_DATA && !BUS.irdy_n && !t_trdy_n;

	always_comb begin
		t_state_next = t_state_reg;
		t_wr_next    = t_wr_reg;
		t_rdata_next = t_rdata_reg;
		unique case (t_state_reg)
			T_IDLE: begin
				// own address phase is never decoded
				if (frame_start && hit && cmd_ok && m_state_reg != M_ADDR) begin
					t_wr_next    = BUS.cbe_n[3:0] == `PXB_CMD_MEM_WR;
					t_rdata_next = TGT_RDATA_I;
					t_state_next = T_DATA;
				end
			end
			T_DATA: begin
				if (t_xfer) begin
					if (!t_wr_reg) begin
						t_rdata_next = TGT_RDATA_I;
					end
					if (BUS.frame_n) begin
						t_state_next = T_TURN;
					end
				end
			end
			T_TURN: begin
				t_state_next = T_IDLE;
			end
		endcase
	end

	// ==========================================================
	// parity follows whatever this end drove on the lanes
	always_comb begin
		par_next    = ^{BUS.ad[31:0], BUS.cbe_n[3:0]};
		par_oe_next = BUS.d_ad_oe;
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			m_state_reg    <= M_IDLE;
			t_state_reg    <= T_IDLE;
			m_addr_reg     <= `PXB_RESET_WORD;
			m_data_reg     <= `PXB_RESET_WORD;
			m_rdata_reg    <= `PXB_RESET_WORD;
			t_rdata_reg    <= `PXB_RESET_WORD;
			m_be_n_reg     <= '1;
			m_wr_reg       <= 1'b0;
			t_wr_reg       <= 1'b0;
			m_cnt_reg      <= '0;
			done_reg       <= 1'b0;
			abort_reg      <= 1'b0;
			frame_prev_reg <= 1'b1;
			par_reg        <= 1'b0;
			par_oe_reg     <= 1'b0;
		end else begin
			m_state_reg    <= m_state_next;
			t_state_reg    <= t_state_next;
			m_addr_reg     <= m_addr_next;
			m_data_reg     <= m_data_next;
			m_rdata_reg    <= m_rdata_next;
			t_rdata_reg    <= t_rdata_next;
			m_be_n_reg     <= m_be_n_next;
			m_wr_reg       <= m_wr_next;
			t_wr_reg       <= t_wr_next;
			m_cnt_reg      <= m_cnt_next;
			done_reg       <= done_next;
			abort_reg      <= abort_next;
			frame_prev_reg <= BUS.frame_n;
			par_reg        <= par_next;
			par_oe_reg     <= par_oe_next;
		end
	end

	// ==========================================================
	// pin drive
	assign m_ad_oe = m_state_reg == M_ADDR || (m_state_reg == M_DATA && m_wr_reg);
	assign t_ad_oe = t_state_reg == T_DATA && !t_wr_reg;

	always_comb begin
		BUS.req_n     = m_state_reg != M_REQ;
		BUS.d_mctl_oe = m_state_reg == M_ADDR || m_state_reg == M_DATA || m_state_reg == M_TURN;
		BUS.d_frame_n = m_state_reg != M_ADDR;
		BUS.d_irdy_n  = m_state_reg != M_DATA;
		BUS.d_cbe_oe  = m_state_reg == M_ADDR || m_state_reg == M_DATA;
		// command then held byte enables
		BUS.d_cbe_n   = (m_state_reg == M_ADDR) ?
			{`PXB_CBE_UPPER, m_wr_reg ? `PXB_CMD_MEM_WR : `PXB_CMD_MEM_RD} : m_be_n_reg;
		BUS.d_ad_oe   = m_ad_oe || t_ad_oe;
		BUS.d_ad      = m_ad_oe ? ((m_state_reg == M_ADDR) ? m_addr_reg : m_data_reg) :
			t_rdata_reg;
		BUS.d_tctl_oe = t_state_reg != T_IDLE;
		BUS.d_devsel_n = t_state_reg != T_DATA;
		BUS.d_ack64_n  = t_state_reg != T_DATA;
		BUS.d_trdy_n   = t_trdy_n;
		BUS.d_par      = par_reg;
		BUS.d_par_oe   = par_oe_reg;
	end

	// ==========================================================
	// write stream, byte enables kept with the data
	pxb_fifo #(
		.WIDTH(`PXB_FIFO_WIDTH),
		.DEPTH(`PXB_FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i       (CLK_I),
		.rst_i       (RST_I),
		.in_valid_i  (t_xfer && t_wr_reg),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   ({BUS.cbe_n, BUS.ad}),
		.out_valid_o (RX_VALID_O),
		.out_ready_i (RX_READY_I),
		.out_data_o  (RX_DATA_O)
	);

	assign MST_BUSY_O  = m_state_reg != M_IDLE;
	assign MST_DONE_O  = done_reg;
	assign MST_ABORT_O = abort_reg;
	assign MST_RDATA_O = m_rdata_reg;
	assign TGT_RD_O    = t_xfer && !t_wr_reg;
endmodule

//--- src/pxb_host_end.sv
// Purpose: host end of the bus: arbiter, master and one-word target
// Assumes: device end requests through the request line
// Notes:   host master yields while the device requests
`include "pxb_params.svh"

module pxb_host_end import pxb_pkg::*; (
	// system
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// bus
	pxb_bus_if.host          BUS,
	// master request
	input  wire logic        HM_START_I,
	input  wire logic        HM_WRITE_I,
	input  wire logic [63:0] HM_ADDR_I,
	input  wire logic [63:0] HM_DATA_I,
	input  wire logic [7:0]  HM_BE_N_I,
	// master answer
	output logic             HM_BUSY_O,
	output logic             HM_DONE_O,
	output logic             HM_ABORT_O,
	output logic      [63:0] HM_RDATA_O,
	// target word
	output logic      [63:0] HT_WORD_O
);
	pxb_mst_t    m_state_reg, m_state_next;
	pxb_tgt_t    t_state_reg, t_state_next;
	logic [63:0] m_addr_reg, m_addr_next, m_data_reg, m_data_next;
	logic [63:0] m_rdata_reg, m_rdata_next, word_reg, word_next;
	logic [7:0]  m_be_n_reg, m_be_n_next;
	logic        m_wr_reg, m_wr_next, t_wr_reg, t_wr_next;
	logic [2:0]  m_cnt_reg, m_cnt_next;
	logic        done_reg, done_next, abort_reg, abort_next, gnt_n_reg, gnt_n_next;
	logic        frame_prev_reg, par_reg, par_oe_reg, t_xfer, m_ad_oe;

	assign t_xfer = t_state_reg == T_DATA && !BUS.irdy_n;

	// ==========================================================
	// arbiter, master and target
	always_comb begin
		m_state_next = m_state_reg;
		m_addr_next  = m_addr_reg;
		m_data_next  = m_data_reg;
		m_be_n_next  = m_be_n_reg;
		m_wr_next    = m_wr_reg;
		m_rdata_next = m_rdata_reg;
		m_cnt_next   = m_cnt_reg;
		done_next    = 1'b0;
		abort_next   = 1'b0;
		// a waiting host master yields, so both requesting cannot deadlock
		gnt_n_next   = !(!BUS.req_n && (m_state_reg == M_IDLE || m_state_reg == M_REQ));
		t_state_next = t_state_reg;
		t_wr_next    = t_wr_reg;
		word_next    = word_reg;
		unique case (m_state_reg)
			M_IDLE: begin
				if (HM_START_I) begin
					m_addr_next  = HM_ADDR_I;
					m_data_next  = HM_DATA_I;
					m_be_n_next  = HM_BE_N_I;
					m_wr_next    = HM_WRITE_I;
					m_state_next = M_REQ;
				end
			end
			M_REQ: begin
				if (gnt_n_reg && BUS.req_n && BUS.frame_n && BUS.irdy_n) begin
					m_state_next = M_ADDR;
				end
			end
			M_ADDR: begin
				m_cnt_next   = '0;
				m_state_next = M_DATA;
			end
			M_DATA: begin
				if (!BUS.trdy_n) begin
					if (!m_wr_reg) begin
						m_rdata_next = BUS.ad;
					end
					done_next    = 1'b1;
					m_state_next = M_TURN;
				end else if (BUS.devsel_n && m_cnt_reg == `PXB_DEVSEL_WAIT) begin
					abort_next   = 1'b1;
					m_state_next = M_TURN;
				end else if (m_cnt_reg != `PXB_DEVSEL_WAIT) begin
					m_cnt_next = m_cnt_reg + 3'h1;
				end
			end
			M_TURN: begin
				m_state_next = M_IDLE;
			end
		endcase
		unique case (t_state_reg)
			T_IDLE: begin
				if (!BUS.frame_n && frame_prev_reg && m_state_reg != M_ADDR &&
					(BUS.ad & `PXB_WIN_MASK) == `PXB_HOST_BASE &&
					(BUS.cbe_n[3:0] == `PXB_CMD_MEM_RD ||
					BUS.cbe_n[3:0] == `PXB_CMD_MEM_WR)) begin
					t_wr_next    = BUS.cbe_n[3:0] == `PXB_CMD_MEM_WR;
					t_state_next = T_DATA;
				end
			end
			T_DATA: begin
				if (t_xfer) begin
					for (int i = 0; i < 8; i++) begin
						if (t_wr_reg && !BUS.cbe_n[i]) begin
							word_next[8*i +: 8] = BUS.ad[8*i +: 8];
						end
					end
					if (BUS.frame_n) begin
						t_state_next = T_TURN;
					end
				end
			end
			T_TURN: begin
				t_state_next = T_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			m_state_reg    <= M_IDLE;
			t_state_reg    <= T_IDLE;
			m_addr_reg     <= `PXB_RESET_WORD;
			m_data_reg     <= `PXB_RESET_WORD;
			m_rdata_reg    <= `PXB_RESET_WORD;
			word_reg       <= `PXB_RESET_WORD;
			m_be_n_reg     <= '1;
			m_wr_reg       <= 1'b0;
			t_wr_reg       <= 1'b0;
			m_cnt_reg      <= '0;
			done_reg       <= 1'b0;
			abort_reg      <= 1'b0;
			gnt_n_reg      <= 1'b1;
			frame_prev_reg <= 1'b1;
			par_reg        <= 1'b0;
			par_oe_reg     <= 1'b0;
		end else begin
			m_state_reg    <= m_state_next;
			t_state_reg    <= t_state_next;
			m_addr_reg     <= m_addr_next;
			m_data_reg     <= m_data_next;
			m_rdata_reg    <= m_rdata_next;
			word_reg       <= word_next;
			m_be_n_reg     <= m_be_n_next;
			m_wr_reg       <= m_wr_next;
			t_wr_reg       <= t_wr_next;
			m_cnt_reg      <= m_cnt_next;
			done_reg       <= done_next;
			abort_reg      <= abort_next;
			gnt_n_reg      <= gnt_n_next;
			frame_prev_reg <= BUS.frame_n;
			par_reg        <= ^{BUS.ad[31:0], BUS.cbe_n[3:0]};
			par_oe_reg     <= BUS.h_ad_oe;
		end
	end

	// ==========================================================
	// pin drive
	assign m_ad_oe = m_state_reg == M_ADDR || (m_state_reg == M_DATA && m_wr_reg);

	always_comb begin
		BUS.gnt_n      = gnt_n_reg;
		BUS.h_mctl_oe  = m_state_reg == M_ADDR || m_state_reg == M_DATA || m_state_reg == M_TURN;
		BUS.h_frame_n  = m_state_reg != M_ADDR;
		BUS.h_irdy_n   = m_state_reg != M_DATA;
		BUS.h_cbe_oe   = m_state_reg == M_ADDR || m_state_reg == M_DATA;
		BUS.h_cbe_n    = (m_state_reg == M_ADDR) ?
			{`PXB_CBE_UPPER, m_wr_reg ? `PXB_CMD_MEM_WR : `PXB_CMD_MEM_RD} : m_be_n_reg;
		BUS.h_ad_oe    = m_ad_oe || (t_state_reg == T_DATA && !t_wr_reg);
		BUS.h_ad       = m_ad_oe ? ((m_state_reg == M_ADDR) ? m_addr_reg : m_data_reg) :
			word_reg;
		BUS.h_tctl_oe  = t_state_reg != T_IDLE;
		BUS.h_devsel_n = t_state_reg != T_DATA;
		BUS.h_ack64_n  = t_state_reg != T_DATA;
		BUS.h_trdy_n   = t_state_reg != T_DATA;
		BUS.h_par      = par_reg;
		BUS.h_par_oe   = par_oe_reg;
	end

	assign HM_BUSY_O  = m_state_reg != M_IDLE;
	assign HM_DONE_O  = done_reg;
	assign HM_ABORT_O = abort_reg;
	assign HM_RDATA_O = m_rdata_reg;
	assign HT_WORD_O  = word_reg;
endmodule

//--- testbench/pxb_bus_chk_sva.sv
// Purpose: protocol checker on the resolved bus wires
// Assumes: one bus clock, synchronous active-high reset
// Notes:   sees only interface signals; instantiated beside the interface
`include "pxb_params.svh"

module pxb_bus_chk (
	// system
	input wire logic        CLK_I,
	input wire logic        RST_I,
	// resolved bus
	input wire logic [63:0] ad,
	input wire logic [7:0]  cbe_n,
	input wire logic        frame_n,
	input wire logic        irdy_n,
	input wire logic        trdy_n,
	input wire logic        devsel_n,
	input wire logic        ack64_n,
	input wire logic        par,
	input wire logic        gnt_n,
	input wire logic        d_mctl_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// address decode
	logic hit;
	assign hit = ((ad & `PXB_WIN_MASK) == `PXB_DEV_BASE)
		|| ((ad & `PXB_WIN_MASK) == `PXB_HOST_BASE);

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	// ==========================================================
	// properties
	property p_frame;
		$fell(frame_n) |=> (frame_n && !irdy_n);
	endproperty
	a_frame: assert property (p_frame) else $error("frame not released in data phase");

	property p_claim;
		(!frame_n && hit) |=> !devsel_n;
	endproperty
	a_claim: assert property (p_claim) else $error("window hit not claimed");

	property p_refuse;
		(!frame_n && !hit) |=> devsel_n;
	endproperty
	a_refuse: assert property (p_refuse) else $error("foreign address claimed");

	property p_abort;
		$fell(frame_n) ##1 devsel_n [*5] |-> ##[1:2] irdy_n;
	endproperty
	a_abort: assert property (p_abort) else $error("master kept waiting unclaimed");

	property p_ack;
		$fell(devsel_n) |-> !ack64_n;
	endproperty
	a_ack: assert property (p_ack) else $error("claim without wide acknowledge");

	property p_cmd;
		!frame_n |-> (cbe_n[7:4] == `PXB_CBE_UPPER)
			&& (cbe_n[3:0] == `PXB_CMD_MEM_RD || cbe_n[3:0] == `PXB_CMD_MEM_WR);
	endproperty
	a_cmd: assert property (p_cmd) else $error("bad command in address phase");

	property p_be;
		(!irdy_n && $past(irdy_n) == 1'b0) |-> $stable(cbe_n);
	endproperty
	a_be: assert property (p_be) else $error("byte enables moved in data phase");

	property p_done;
		(!irdy_n && !trdy_n) |=> irdy_n;
	endproperty
	a_done: assert property (p_done) else $error("beat did not end the data phase");

	property p_par;
		$fell(frame_n) |=> (par == ^{$past(ad[31:0]), $past(cbe_n[3:0])});
	endproperty
	a_par: assert property (p_par) else $error("address parity wrong");

	property p_gnt;
		$rose(d_mctl_oe) |-> ($past(gnt_n) == 1'b0);
	endproperty
	a_gnt: assert property (p_gnt) else $error("device drove bus without grant");
endmodule

//--- testbench/test_pcix_bus_agent_signaling.sv
// Purpose: runs both bus ends against each other and judges the results
// Assumes: 25 MHz clock, synchronous active-high reset
// Notes:   inputs change 1 ns after the rising edge
`include "pxb_params.svh"

module test_pcix_bus_agent_signaling;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// stimulus and observed signals
	logic        CLK_I, RST_I, mst_start, mst_write, mst_busy, mst_done, mst_abort;
	logic [63:0] mst_addr, mst_data, mst_rdata, tgt_rdata, hm_addr, hm_data, hm_rdata, ht_word;
	logic [7:0]  mst_be_n, hm_be_n;
	logic        tgt_rd, rx_valid, rx_ready, hm_start, hm_write, hm_busy, hm_done, hm_abort;
	logic [71:0] rx_data;
	int          num_errors, samples_checked, cycles, rd_count;

	pxb_bus_if bus ();
	pxb_dev_end pxb_dev_end_inst (.CLK_I(CLK_I), .RST_I(RST_I), .BUS(bus.dev),
		.MST_START_I(mst_start), .MST_WRITE_I(mst_write), .MST_ADDR_I(mst_addr),
		.MST_DATA_I(mst_data), .MST_BE_N_I(mst_be_n), .MST_BUSY_O(mst_busy),
		.MST_DONE_O(mst_done), .MST_ABORT_O(mst_abort), .MST_RDATA_O(mst_rdata),
		.TGT_RDATA_I(tgt_rdata), .TGT_RD_O(tgt_rd), .RX_VALID_O(rx_valid),
		.RX_READY_I(rx_ready), .RX_DATA_O(rx_data));
	pxb_host_end pxb_host_end_inst (.CLK_I(CLK_I), .RST_I(RST_I), .BUS(bus.host),
		.HM_START_I(hm_start), .HM_WRITE_I(hm_write), .HM_ADDR_I(hm_addr),
		.HM_DATA_I(hm_data), .HM_BE_N_I(hm_be_n), .HM_BUSY_O(hm_busy), .HM_DONE_O(hm_done),
		.HM_ABORT_O(hm_abort), .HM_RDATA_O(hm_rdata), .HT_WORD_O(ht_word));
	pxb_bus_chk pxb_bus_chk_inst (.CLK_I(CLK_I), .RST_I(RST_I), .ad(bus.ad),
		.cbe_n(bus.cbe_n), .frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .trdy_n(bus.trdy_n),
		.devsel_n(bus.devsel_n), .ack64_n(bus.ack64_n), .par(bus.par), .gnt_n(bus.gnt_n),
		.d_mctl_oe(bus.d_mctl_oe));

	initial begin
		CLK_I = 1'b0;
		forever #20 CLK_I = ~CLK_I;
	end

	// ==========================================================
	// helpers
	task automatic tick();
		@(posedge CLK_I);
		#1;
	endtask

	task automatic check_val(input string what, input logic [71:0] exp, input logic [71:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_flag(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask

	function automatic logic [63:0] word_of(input int i);
		return 64'h0123_4567_89ab_cd00 | 64'(i);
	endfunction

	// device master transfer with wire checks; data is the expected read word on reads
	task automatic dev_op(input logic wr, input logic [63:0] addr, input logic [63:0] data,
			input logic [7:0] be_n, input logic hit);
		int n;
		mst_write = wr;
		mst_addr = addr;
		mst_data = data;
		mst_be_n = be_n;
		mst_start = 1'b1;
		tick();
		mst_start = 1'b0;
		check_flag("master busy", 1'b1, mst_busy);
		for (n = 0; n < 8 && bus.frame_n !== 1'b0; n++) tick();
		check_val("address lanes", {8'h00, addr}, {8'h00, bus.ad});
		check_val("command", {68'h0, wr ? 4'h7 : 4'h6}, {64'h0, bus.cbe_n});
		tick();
		check_flag("address parity", ^{addr[31:0], wr ? 4'h7 : 4'h6}, bus.par);
		check_val("byte enables", {64'h0, be_n}, {64'h0, bus.cbe_n});
		check_flag("device select", !hit, bus.devsel_n);
		if (hit) begin
			check_flag("wide acknowledge", 1'b0, bus.ack64_n);
			check_val("data lanes", {8'h00, data}, {8'h00, bus.ad});
		end
		for (n = 0; n < 12 && !mst_done && !mst_abort; n++) tick();
		check_flag("master done", hit, mst_done);
		check_flag("master abort", !hit, mst_abort);
		if (hit && !wr) check_val("master read", {8'h00, data}, {8'h00, mst_rdata});
		repeat (3) tick();
	endtask

	task automatic host_go(input logic wr, input logic [63:0] addr, input logic [63:0] data,
			input logic [7:0] be_n);
		hm_write = wr;
		hm_addr = addr;
		hm_data = data;
		hm_be_n = be_n;
		hm_start = 1'b1;
		tick();
		hm_start = 1'b0;
	endtask

	task automatic host_wait(input logic hit);
		int n;
		for (n = 0; n < 12 && !hm_done && !hm_abort; n++) tick();
		check_flag("host done", hit, hm_done);
		check_flag("host abort", !hit, hm_abort);
		repeat (3) tick();
	endtask

	task automatic rx_pop(input logic [71:0] exp);
		int n;
		for (n = 0; n < 12 && !rx_valid; n++) tick();
		check_val("stream word", exp, rx_data);
		rx_ready = 1'b1;
		tick();
		rx_ready = 1'b0;
		tick();
	endtask

	// ==========================================================
	// scenarios
	task automatic scn_dev_write_read();
		dev_op(1'b1, `PXB_HOST_BASE, 64'h1122_3344_5566_7788, 8'h00, 1'b1);
		dev_op(1'b1, `PXB_HOST_BASE + 64'h8, 64'h99aa_bbcc_ddee_ff00, 8'h0f, 1'b1);
		check_val("host word", {8'h00, 64'h99aa_bbcc_5566_7788}, {8'h00, ht_word});
		dev_op(1'b0, `PXB_HOST_BASE, 64'h99aa_bbcc_5566_7788, 8'h00, 1'b1);
	endtask

	task automatic scn_unclaimed();
		dev_op(1'b1, 64'h0000_0000_4000_0000, 64'h5555_aaaa_5555_aaaa, 8'h00, 1'b0);
		dev_op(1'b0, 64'h0000_0000_4000_0000, 64'h0, 8'h00, 1'b0);
		host_go(1'b1, 64'h0000_0000_4000_0000, 64'h0, 8'h00);
		host_wait(1'b0);
	endtask

	task automatic scn_host_read();
		tgt_rdata = 64'hfeed_0000_1357_2468;
		host_go(1'b0, `PXB_DEV_BASE + 64'h10, 64'h0, 8'h00);
		host_wait(1'b1);
		check_val("host read", {8'h00, tgt_rdata}, {8'h00, hm_rdata});
		check_val("target reads", 72'h1, 72'(rd_count));
	endtask

	task automatic scn_fifo_fill();
		int i;
		for (i = 0; i < 16; i++) begin
			host_go(1'b1, `PXB_DEV_BASE + 64'(i * 8), word_of(i), 8'(i));
			host_wait(1'b1);
		end
		check_flag("stream valid", 1'b1, rx_valid);
		host_go(1'b1, `PXB_DEV_BASE + 64'h80, word_of(16), 8'h10);
		repeat (8) tick();
		check_flag("host stalled", 1'b1, hm_busy);
		rx_pop({8'h00, word_of(0)});
		host_wait(1'b1);
		for (i = 1; i < 17; i++) rx_pop({8'(i), word_of(i)});
		check_flag("stream empty", 1'b0, rx_valid);
	endtask

	// both masters start at the same edge; the device is granted first
	task automatic scn_contend();
		int n;
		mst_write = 1'b1;
		mst_addr = `PXB_HOST_BASE;
		mst_data = word_of(32);
		mst_be_n = 8'h00;
		hm_write = 1'b1;
		hm_addr = `PXB_DEV_BASE;
		hm_data = word_of(33);
		hm_be_n = 8'h00;
		mst_start = 1'b1;
		hm_start = 1'b1;
		tick();
		mst_start = 1'b0;
		hm_start = 1'b0;
		for (n = 0; n < 12 && !mst_done; n++) tick();
		check_flag("contended master done", 1'b1, mst_done);
		host_wait(1'b1);
		check_val("contended host word", {8'h00, word_of(32)}, {8'h00, ht_word});
		rx_pop({8'h00, word_of(33)});
	endtask

	// ==========================================================
	// closing, watchdog and main sequence
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge CLK_I) begin
		if (tgt_rd === 1'b1) rd_count++;
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			complete_run();
		end
	end

	initial begin
		{num_errors, samples_checked, cycles, rd_count} = '0;
		{mst_start, mst_write, mst_addr, mst_data, mst_be_n, tgt_rdata} = '0;
		{hm_start, hm_write, hm_addr, hm_data, hm_be_n, rx_ready} = '0;
		RST_I = 1'b1;
		repeat (3) @(posedge CLK_I);
		#1;
		RST_I = 1'b0;
		tick();
		scn_dev_write_read();
		scn_unclaimed();
		scn_host_read();
		scn_fifo_fill();
		scn_contend();
		complete_run();
	end
endmodule
